// [core/pcs_cfg_defs.svh]
// Constants for the 100 Mb/s coding sublayer configuration register bank.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PCS_CFG_DEFS_SVH
`define PCS_CFG_DEFS_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define PCS_IDX_CFG_STATUS 8'h16
`define PCS_IDX_SUMMARY 8'h10

// ------------------------------------------------------------
// Field positions of the configuration register
// ------------------------------------------------------------
`define PCS_BIT_RX_FREE_CLK 11
`define PCS_BIT_TRUE_QUIET 10
`define PCS_BIT_SD_OVERRIDE 9
`define PCS_BIT_SD_POLICY 8
`define PCS_BIT_DESC_TIMEOUT 7
`define PCS_BIT_FORCE_GOOD 5
`define PCS_BIT_NRZI_BYPASS 2

// Writable bits; reserved positions stay zero whatever is written
`define PCS_CFG_WR_MASK 16'h0fa4
`define PCS_CFG_RESET 16'h0100

// ------------------------------------------------------------
// Field positions of the summary status register
// ------------------------------------------------------------
`define PCS_SUM_BIT_LINK 0
`define PCS_SUM_BIT_TIMEOUT 1
`define PCS_SUM_BIT_LEVEL 2
`define PCS_SUM_BIT_LOCK 3
`define PCS_SUM_BIT_LINK100 4

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PCS_CLK_PERIOD_NS 8
`define PCS_DESC_SHORT_NS 722000
`define PCS_DESC_LONG_NS 2000000
`define PCS_TIMER_W 18

`endif

// [core/pcs_cfg_top.sv]
// Configuration and status register bank of the 100 Mb/s coding sublayer.
// Assumes an Avalon-MM master on SYS_CLK and line pins from other clock domains.
//
// Function
// - Bits 15:13 read zero, writes dropped
// - True-quiet field quiets 100 Mb/s transmitter
// - Override field forces signal detect asserted
// - Policy one: link held by level alone
// - Policy zero: link needs level and lock
// - Timeout select: 2 ms or 722 us
// - Force-good field forces 100 Mb/s link
// - Bypass field skips NRZI coding
// - Summary link bit not cleared by read
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "pcs_cfg_defs.svh"

module pcs_cfg_top
  import pcs_pkg::*;
#(
  parameter int DESC_SHORT_CYCLES = `PCS_DESC_SHORT_NS / `PCS_CLK_PERIOD_NS,
  parameter int DESC_LONG_CYCLES = `PCS_DESC_LONG_NS / `PCS_CLK_PERIOD_NS
)
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic SIG_LEVEL_OK,
  input wire logic DESC_LOCK,
  input wire logic DESC_SYNC,
  input wire logic LINK_10_OK,
  output logic TX_TRUE_QUIET,
  output logic PMA_SIGNAL_DETECT,
  output logic DESC_TIMEOUT_LONG,
  output logic LINK_100_GOOD,
  output logic NRZI_BYPASS,
  output logic RX_FREE_CLK,
  output logic LINK_STATUS
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] idx);
    addr_hit = (addr == {idx[5:0], 2'b00});
  endfunction : addr_hit

  function automatic pcs_cfg_t unpack_cfg(input logic [15:0] word);
    pcs_cfg_t c;
    c.rx_free_clk = word[`PCS_BIT_RX_FREE_CLK];
    c.true_quiet_enable = word[`PCS_BIT_TRUE_QUIET];
    c.signal_detect_override = word[`PCS_BIT_SD_OVERRIDE];
    c.signal_detect_policy = word[`PCS_BIT_SD_POLICY];
    c.descrambler_timeout_select = word[`PCS_BIT_DESC_TIMEOUT];
    c.force_good_link = word[`PCS_BIT_FORCE_GOOD];
    c.nrzi_bypass = word[`PCS_BIT_NRZI_BYPASS];
    unpack_cfg = c;
  endfunction : unpack_cfg

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  logic rst_n;
  assign rst_n = rst_sync_ff;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [3:0] pin_meta_ff;
  logic [3:0] pin_sync_ff;
  logic sync_prev_ff;

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_ff <= 4'h0;
      pin_sync_ff <= 4'h0;
      sync_prev_ff <= 1'b0;
    end
    else
    begin
      pin_meta_ff <= {DESC_SYNC, LINK_10_OK, DESC_LOCK, SIG_LEVEL_OK};
      pin_sync_ff <= pin_meta_ff;
      sync_prev_ff <= pin_sync_ff[3];
    end
  end

  pcs_line_t line;
  logic sync_evt;

  always_comb
  begin
    line.level_ok = pin_sync_ff[0];
    line.desc_lock = pin_sync_ff[1];
    line.link_10 = pin_sync_ff[2];
    // Rising edge of the descrambler sync strobe restarts the watchdog
    sync_evt = pin_sync_ff[3] & ~sync_prev_ff;
  end

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  // One wait state: a read is decoded in the first cycle and a write in the second; both are answered in the second
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [15:0] cfg_ff;
  logic [15:0] nxt_cfg;
  logic [15:0] summary;
  logic req;
  logic wr_take;
  localparam logic [15:0] cfg_wr_mask = `PCS_CFG_WR_MASK;

  assign req = AVS_READ | AVS_WRITE;
  assign wr_take = AVS_WRITE & ack_ff;

  always_comb
  begin
    nxt_ack = req & ~ack_ff;
    nxt_rdata = rdata_ff;
    if (AVS_READ && !ack_ff)
    begin
      if (addr_hit(AVS_ADDRESS, `PCS_IDX_CFG_STATUS))
      begin
        nxt_rdata = {16'h0000, cfg_ff};
      end
      else if (addr_hit(AVS_ADDRESS, `PCS_IDX_SUMMARY))
      begin
        // Reading has no side effect on any status bit
        nxt_rdata = {16'h0000, summary};
      end
      else
      begin
        nxt_rdata = 32'h0000_0000;
      end
    end
  end

  always_comb
  begin
    nxt_cfg = cfg_ff;
    if (wr_take && addr_hit(AVS_ADDRESS, `PCS_IDX_CFG_STATUS))
    begin
      // Reserved positions are not stored, so a careless write cannot set them
      if (AVS_BYTEENABLE[0])
      begin
        nxt_cfg[7:0] = AVS_WRITEDATA[7:0] & cfg_wr_mask[7:0];
      end
      if (AVS_BYTEENABLE[1])
      begin
        nxt_cfg[15:8] = AVS_WRITEDATA[15:8] & cfg_wr_mask[15:8];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      cfg_ff <= `PCS_CFG_RESET;
    end
    else
    begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      cfg_ff <= nxt_cfg;
    end
  end

  assign AVS_WAITREQUEST = req & ~ack_ff;
  assign AVS_READDATA = rdata_ff;

  pcs_cfg_t cfg;
  assign cfg = unpack_cfg(cfg_ff);

  // ------------------------------------------------------------
  // Descrambler lock watchdog
  // ------------------------------------------------------------
  logic lock_timed_out;

  pcs_desc_timer #(
    .SHORT_CYCLES(DESC_SHORT_CYCLES),
    .LONG_CYCLES(DESC_LONG_CYCLES)
  ) u_desc_timer (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .lock_in(line.desc_lock),
    .sync_evt(sync_evt),
    .long_sel(cfg.descrambler_timeout_select),
    .timed_out(lock_timed_out)
  );

  // ------------------------------------------------------------
  // Link qualification
  // ------------------------------------------------------------
  pcs_link_state_t state_ff;
  pcs_link_state_t nxt_state;
  logic sd_eff;
  logic lock_eff;

  always_comb
  begin
    sd_eff = line.level_ok | cfg.signal_detect_override;
    lock_eff = line.desc_lock & ~lock_timed_out;
    nxt_state = state_ff;
    case (state_ff)
      PCS_LINK_DOWN:
      begin
        if (sd_eff && lock_eff)
        begin
          nxt_state = PCS_LINK_UP;
        end
      end
      PCS_LINK_UP:
      begin
        if (cfg.signal_detect_policy)
        begin
          // Loss of lock alone keeps the link, only the level can drop it
          if (!sd_eff)
          begin
            nxt_state = PCS_LINK_DOWN;
          end
        end
        else if (!sd_eff || !lock_eff)
        begin
          nxt_state = PCS_LINK_DOWN;
        end
      end
      default:
      begin
        nxt_state = PCS_LINK_DOWN;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= PCS_LINK_DOWN;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------
  // Outputs and summary status
  // ------------------------------------------------------------
  logic link100_ff;
  logic nxt_link100;
  logic link_ff;
  logic nxt_link;
  logic sd_out_ff;
  logic nxt_sd_out;

  always_comb
  begin
    nxt_link100 = (state_ff == PCS_LINK_UP) | cfg.force_good_link;
    nxt_link = nxt_link100 | line.link_10;
    nxt_sd_out = sd_eff;
  end

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link100_ff <= 1'b0;
      link_ff <= 1'b0;
      sd_out_ff <= 1'b0;
    end
    else
    begin
      link100_ff <= nxt_link100;
      link_ff <= nxt_link;
      sd_out_ff <= nxt_sd_out;
    end
  end

  always_comb
  begin
    summary = 16'h0000;
    summary[`PCS_SUM_BIT_LINK] = link_ff;
    summary[`PCS_SUM_BIT_TIMEOUT] = lock_timed_out;
    summary[`PCS_SUM_BIT_LEVEL] = line.level_ok;
    summary[`PCS_SUM_BIT_LOCK] = lock_eff;
    summary[`PCS_SUM_BIT_LINK100] = link100_ff;
  end

  assign TX_TRUE_QUIET = cfg.true_quiet_enable;
  assign PMA_SIGNAL_DETECT = sd_out_ff;
  assign DESC_TIMEOUT_LONG = cfg.descrambler_timeout_select;
  assign LINK_100_GOOD = link100_ff;
  assign NRZI_BYPASS = cfg.nrzi_bypass;
  assign RX_FREE_CLK = cfg.rx_free_clk;
  assign LINK_STATUS = link_ff;

endmodule : pcs_cfg_top

`default_nettype wire

// [core/pcs_desc_timer.sv]
// Descrambler lock watchdog: flags loss of lock when no sync event arrives in time.
// Assumes sync_evt is a one-cycle pulse on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "pcs_cfg_defs.svh"

module pcs_desc_timer
  import pcs_pkg::*;
#(
  parameter int SHORT_CYCLES = `PCS_DESC_SHORT_NS / `PCS_CLK_PERIOD_NS,
  parameter int LONG_CYCLES = `PCS_DESC_LONG_NS / `PCS_CLK_PERIOD_NS
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lock_in,
  input wire logic sync_evt,
  input wire logic long_sel,
  output logic timed_out
);

  logic [`PCS_TIMER_W-1:0] count_ff;
  logic [`PCS_TIMER_W-1:0] nxt_count;
  logic expired_ff;
  logic nxt_expired;
  logic [`PCS_TIMER_W-1:0] limit;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    limit = long_sel ? `PCS_TIMER_W'(LONG_CYCLES - 1) : `PCS_TIMER_W'(SHORT_CYCLES - 1);
    nxt_count = count_ff;
    nxt_expired = expired_ff;
    if (!lock_in || sync_evt)
    begin
      nxt_count = '0;
      nxt_expired = 1'b0;
    end
    else if (count_ff >= limit)
    begin
      // Select change mid-count takes effect at once against the new limit
      nxt_expired = 1'b1;
    end
    else
    begin
      nxt_count = count_ff + `PCS_TIMER_W'(1);
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_ff <= '0;
      expired_ff <= 1'b0;
    end
    else
    begin
      count_ff <= nxt_count;
      expired_ff <= nxt_expired;
    end
  end

  assign timed_out = expired_ff;

endmodule : pcs_desc_timer

`default_nettype wire

// [core/pcs_pkg.sv]
// Types shared by the coding sublayer configuration bank.
// Assumes the constants header sits beside it.
`include "pcs_cfg_defs.svh"

package pcs_pkg;

  // Software-visible configuration fields as the logic uses them
  typedef struct packed {
    logic rx_free_clk;
    logic true_quiet_enable;
    logic signal_detect_override;
    logic signal_detect_policy;
    logic descrambler_timeout_select;
    logic force_good_link;
    logic nrzi_bypass;
  } pcs_cfg_t;

  // Synchronised line conditions
  typedef struct packed {
    logic level_ok;
    logic desc_lock;
    logic link_10;
  } pcs_line_t;

  typedef enum logic {PCS_LINK_DOWN, PCS_LINK_UP} pcs_link_state_t;

endpackage : pcs_pkg

// [tb/pcs_cfg_top_sva.sv]
// Checker for the config bank's bus answers and control pins.
// Assumes binding to pcs_cfg_top with its ports only.
`timescale 1ns/1ns
`default_nettype none
module pcs_cfg_chk (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic SIG_LEVEL_OK,
  input wire logic LINK_10_OK,
  input wire logic TX_TRUE_QUIET,
  input wire logic PMA_SIGNAL_DETECT,
  input wire logic DESC_TIMEOUT_LONG,
  input wire logic LINK_100_GOOD,
  input wire logic NRZI_BYPASS,
  input wire logic LINK_STATUS
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);
  logic wr_cfg;
  logic rd_cfg;
  assign wr_cfg = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h58;
  assign rd_cfg = AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h58;
  property p_one_wait;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("wait state count wrong");
  property p_high_zero;
    AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:13] == 19'h0;
  endproperty
  a_high_zero: assert property (p_high_zero)
    else $error("upper read bits not zero");
  property p_rsvd;
    rd_cfg |-> (AVS_READDATA[12:0] & 13'h105b) == 13'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit read back");
  property p_quiet;
    wr_cfg && AVS_BYTEENABLE[1] |=> TX_TRUE_QUIET == $past(AVS_WRITEDATA[10]);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("quiet pin wrong");
  property p_bypass;
    wr_cfg && AVS_BYTEENABLE[0] |=> NRZI_BYPASS == $past(AVS_WRITEDATA[2]);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass pin wrong");
  property p_tmo;
    wr_cfg && AVS_BYTEENABLE[0] |=> DESC_TIMEOUT_LONG == $past(AVS_WRITEDATA[7]);
  endproperty
  a_tmo: assert property (p_tmo)
    else $error("timeout pin wrong");
  // Pin passes two sync flops and one output flop
  property p_detect;
    SIG_LEVEL_OK [*4] |-> PMA_SIGNAL_DETECT;
  endproperty
  a_detect: assert property (p_detect)
    else $error("signal detect low");
  property p_link_or;
    LINK_100_GOOD |-> LINK_STATUS;
  endproperty
  a_link_or: assert property (p_link_or)
    else $error("link status low");
  property p_link_dn;
    (!LINK_10_OK) [*4] ##0 !LINK_100_GOOD |-> !LINK_STATUS;
  endproperty
  a_link_dn: assert property (p_link_dn)
    else $error("link status high");
endmodule : pcs_cfg_chk
bind pcs_cfg_top pcs_cfg_chk u_chk (.SYS_CLK, .RST_B, .AVS_ADDRESS, .AVS_READ,
  .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
  .SIG_LEVEL_OK, .LINK_10_OK, .TX_TRUE_QUIET, .PMA_SIGNAL_DETECT,
  .DESC_TIMEOUT_LONG, .LINK_100_GOOD, .NRZI_BYPASS, .LINK_STATUS);
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the config bank.
// Assumes an Avalon-MM slave with waitrequest that answers within 20 cycles.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  localparam int FB[6] = '{11, 10, 9, 7, 5, 2};
  logic clk, rst_b, rd, wr, lvl, lock, sync, l10, wt;
  logic quiet, sdet, tlong, good, nrzi, fclk, link;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wdat, rdat, junk;
  int mismatches, tests_run;
  // Short watchdog counts keep the run brief
  pcs_cfg_top #(.DESC_SHORT_CYCLES(20), .DESC_LONG_CYCLES(50)) dut (
    .SYS_CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wt), .SIG_LEVEL_OK(lvl),
    .DESC_LOCK(lock), .DESC_SYNC(sync), .LINK_10_OK(l10),
    .TX_TRUE_QUIET(quiet), .PMA_SIGNAL_DETECT(sdet), .DESC_TIMEOUT_LONG(tlong),
    .LINK_100_GOOD(good), .NRZI_BYPASS(nrzi), .RX_FREE_CLK(fclk),
    .LINK_STATUS(link));
  task summarize;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Request held until the rising edge that samples waitrequest low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [3:0] b, output logic [31:0] q);
    int n;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdat <= d;
    be <= b;
    n = 0;
    @(posedge clk);
    while (wt !== 1'b0)
    begin
      n++;
      if (n > 20)
      begin
        mismatches++;
        summarize();
      end
      @(posedge clk);
    end
    // Read data are taken at the same edge that ends the wait
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task wreg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    bus(1'b1, a, d, b, junk);
  endtask : wreg
  task rreg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(q, e);
  endtask : rreg
  function automatic logic [31:0] outs();
    return {26'h0, fclk, quiet, sdet, tlong, good, nrzi};
  endfunction : outs
  task t_reset;
    rreg(8'h58, 32'h100);
    chk(outs(), 32'h0);
  endtask : t_reset
  task t_fields;
    for (int i = 0; i < 6; i++)
    begin
      wreg(8'h58, 32'h1 << FB[i], 4'h3);
      cyc(4);
      chk(outs(), 32'h20 >> i);
      rreg(8'h58, 32'h1 << FB[i]);
    end
  endtask : t_fields
  // Bits 15:13 and the upper lanes are written as ones, must-be-zero bits stay zero
  task t_rsvd;
    wreg(8'h58, 32'hffffefa4, 4'hf);
    rreg(8'h58, 32'h0fa4);
    wreg(8'h58, 32'h0, 4'h1);
    wreg(8'h00, 32'h0, 4'hf);
    rreg(8'h58, 32'h0f00);
    rreg(8'h00, 32'h0);
  endtask : t_rsvd
  task t_policy(input logic pol);
    wreg(8'h58, {23'h0, pol, 8'h0}, 4'h3);
    lvl <= 1'b1;
    lock <= 1'b1;
    cyc(8);
    chk(32'(good), 32'h1);
    lock <= 1'b0;
    cyc(8);
    chk(32'(good), 32'(pol));
    lvl <= 1'b0;
    cyc(8);
    chk(32'(good), 32'h0);
  endtask : t_policy
  // A sync pulse restarts the watchdog: long mode holds the link, short mode expires again
  task t_timeout(input logic lg);
    wreg(8'h58, {24'h0, lg, 7'h0}, 4'h3);
    lvl <= 1'b1;
    lock <= 1'b1;
    cyc(12);
    chk(32'(good), 32'h1);
    rreg(8'h40, 32'h1d);
    cyc(23);
    chk(32'(good), 32'(lg));
    sync <= 1'b1;
    cyc(1);
    sync <= 1'b0;
    cyc(34);
    chk(32'(good), 32'(lg));
    cyc(40);
    chk(32'(good), 32'h0);
    rreg(8'h40, 32'h6);
    lvl <= 1'b0;
    lock <= 1'b0;
    cyc(4);
  endtask : t_timeout
  task t_summary;
    wreg(8'h58, 32'h100, 4'h3);
    l10 <= 1'b1;
    cyc(5);
    chk(32'(link), 32'h1);
    rreg(8'h40, 32'h1);
    rreg(8'h40, 32'h1);
    l10 <= 1'b0;
    cyc(5);
    chk(32'(link), 32'h0);
  endtask : t_summary
  task t_reset2;
    wreg(8'h58, 32'h0fa4, 4'h3);
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    cyc(2);
    rreg(8'h58, 32'h100);
    chk(outs(), 32'h0);
  endtask : t_reset2
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    {rd, wr, lvl, lock, sync, l10} = 6'h0;
    rst_b = 1'b0;
    addr = 8'h0;
    wdat = 32'h0;
    be = 4'h0;
    mismatches = 0;
    tests_run = 0;
    cyc(4);
    rst_b <= 1'b1;
    cyc(2);
    t_reset();
    t_fields();
    t_rsvd();
    t_policy(1'b1);
    t_policy(1'b0);
    t_timeout(1'b0);
    t_timeout(1'b1);
    t_summary();
    t_reset2();
    summarize();
  end
endmodule : testbench
`default_nettype wire
